/* rtl/usrd_params.svh */
/*
  Constants of the standard request decoder: request codes, field values,
  register offsets and reset values.
  Assumes it is included by bare name wherever a value is needed.
*/
`ifndef USRD_PARAMS_SVH
`define USRD_PARAMS_SVH

// Request codes
`define USRD_RQ_GET_STATUS   8'h00
`define USRD_RQ_CLR_FEATURE  8'h01
`define USRD_RQ_SET_FEATURE  8'h03
`define USRD_RQ_SET_ADDRESS  8'h05
`define USRD_RQ_GET_DESC     8'h06
`define USRD_RQ_GET_CONFIG   8'h08
`define USRD_RQ_SET_CONFIG   8'h09
`define USRD_RQ_GET_IFACE    8'h0a
`define USRD_RQ_SET_IFACE    8'h0b

// Request types
`define USRD_RT_STD_DEV_OUT  8'h00
`define USRD_RT_STD_IF_OUT   8'h01
`define USRD_RT_STD_EP_OUT   8'h02
`define USRD_RT_STD_DEV_IN   8'h80
`define USRD_RT_STD_IF_IN    8'h81
`define USRD_RT_STD_EP_IN    8'h82

// Field values
`define USRD_FEAT_EP_HALT    16'h0000
`define USRD_FEAT_WAKEUP     16'h0001
`define USRD_DESC_DEVICE     16'h0100
`define USRD_DESC_CONFIG     16'h0200
`define USRD_EP0_OUT_IDX     16'h0000
`define USRD_EP0_IN_IDX      16'h0080
`define USRD_EP1_IDX         16'h0081
`define USRD_EP2_IDX         16'h0002
`define USRD_LEN_ONE         16'h0001
`define USRD_LEN_TWO         16'h0002
`define USRD_CFG_ONE         16'h0001
`define USRD_DEV_DESC_LEN    16'h0012
`define USRD_MAX_IFACE       3'h4
`define USRD_DIR_BIT         7
`define USRD_ADDR_TOP        7

// Register offsets
`define USRD_REG_CTRL        4'h0
`define USRD_REG_IFCOUNT     4'h1
`define USRD_REG_ALTMAX      4'h2
`define USRD_REG_EP1MAP      4'h3
`define USRD_REG_EP2MAP      4'h4
`define USRD_REG_CFGLEN_LO   4'h5
`define USRD_REG_CFGLEN_HI   4'h6
`define USRD_REG_CLRFLAGS    4'h7
`define USRD_REG_STATUS      4'h8
`define USRD_REG_ADDR        4'h9
`define USRD_REG_ALTCUR      4'ha

// Bit positions
`define USRD_ST_WAKEUP       0
`define USRD_ST_HALT0        1
`define USRD_ST_HALT1        2
`define USRD_ST_HALT2        3
`define USRD_ST_CONF         4
`define USRD_MAP_ALT         3

// Reset values
`define USRD_RST_BYTE        8'h00
`define USRD_RST_WORD        16'h0000

`endif

/* rtl/usrd_pkg.sv */
/*
  Types of the standard request decoder.
  Assumes usrd_params.svh for the numeric values.
*/
package usrd_pkg;

  typedef enum logic [1:0]
  {
    USRD_DEFAULT    = 2'b00,
    USRD_ADDRESSED  = 2'b01,
    USRD_CONFIGURED = 2'b11
  } usrd_dev_state_t;

  typedef enum logic [3:0]
  {
    USRD_K_NONE, USRD_K_GET_STATUS, USRD_K_CLR_FEATURE, USRD_K_SET_FEATURE,
    USRD_K_SET_ADDRESS, USRD_K_GET_DESC, USRD_K_GET_CONFIG, USRD_K_SET_CONFIG,
    USRD_K_GET_IFACE, USRD_K_SET_IFACE
  } usrd_kind_t;

  typedef struct packed
  {
    logic [15:0] length;
    logic [15:0] index;
    logic [15:0] value;
    logic [7:0]  code;
    logic [7:0]  rtype;
  } usrd_setup_t;

  typedef struct packed
  {
    logic        valid;
    logic        has_data;
    logic        stall;
    logic        fw_decode;
    logic        zlp;
    logic [1:0]  desc_sel;
    logic [15:0] xfer_len;
    logic [15:0] reply;
  } usrd_resp_t;

endpackage

/* rtl/usrd_decoder.sv */
/*
  Standard control request decoder for endpoint 0.
  Takes the eight setup bytes from the serial engine as one word with a strobe,
  decides ACK/NAK versus STALL, data stage and length, and applies feature,
  address and configuration changes when the host ACKs the status stage.
  Assumes the serial engine and registers share one clock and that the host
  follows the control sequence.
*/
// How it works
// - Setup is eight bytes, words low first
// - Recognise the nine standard requests, ep0 index
// - Get requests have data stage, others none
// - Default/Addressed stall interface and non-ep0 endpoint requests
// - Descriptor length is smaller of requested, prepared
// - Clear feature acts on status stage ACK
// - Set feature acts on status stage ACK
// - Ep0 halt stalls all standard requests but three
// - Unsupported stall leaves halt, ends next setup
// - Set configuration above one is stalled
// - Status stage data still gets ACK
// - Firmware read with zero length sends ZLP
// - Interfaces 1 to 4 valid per count
// - Endpoint validity from alternate setting and map
// - Set interface checks number and alternate setting
// - Keep Default, Addressed and Configured states
// - Bad clear feature stalls in status stage
// - Clear feature targets allowed per state
// - Good clear feature flags, unhalts, interrupts
// - Endpoint clear feature resets toggle to DATA0
// - Runs from the single system clock
`timescale 1ns/100ps
`include "usrd_params.svh"

module usrd_decoder
#(
  parameter int NIF = 5
)
(
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_ce,
  input  wire usrd_pkg::usrd_setup_t i_setup,
  input  wire logic                 i_setup_stb,
  input  wire logic                 i_status_ack,
  input  wire logic [3:0]           i_reg_addr,
  input  wire logic [7:0]           i_reg_wdata,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  output logic [7:0]                o_reg_rdata,
  output usrd_pkg::usrd_resp_t      o_resp,
  output logic [6:0]                o_usb_addr,
  output logic [1:0]                o_dev_state,
  output logic [2:0]                o_toggle_reset,
  output logic                      o_clear_irq,
  output logic                      o_config_irq,
  output logic                      o_fw_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  usrd_pkg::usrd_dev_state_t state_q;
  usrd_pkg::usrd_kind_t      kind_q;
  usrd_pkg::usrd_setup_t     pkt_q;
  logic [2:0]                if_count_q;
  logic [NIF-1:0]            alt_max_q;
  logic [NIF-1:0]            alt_cur_q;
  logic [3:0]                ep1_map_q;
  logic [3:0]                ep2_map_q;
  logic [15:0]               cfg_len_q;
  logic [3:0]                clear_request_flags_q;
  logic                      device_status_low_q;
  logic [2:0]                endpoint_halt_flag_q;
  logic                      conf_q;
  logic                      pend_stall_q;
  logic [6:0]                addr_q;
  logic                      ctrl_go_q;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Interface 0 always exists; the rest follow the active count
  function automatic logic iface_ok(input logic [15:0] idx, input logic [2:0] cnt);
    iface_ok = (idx[15:3] == 13'h0000) && (idx[2:0] <= cnt) && (idx[2:0] <= `USRD_MAX_IFACE);
  endfunction

  // Map: low bits interface, top bit alternate setting the endpoint lives in
  function automatic logic ep_live(input logic [3:0] map, input logic [NIF-1:0] alt,
                                   input logic [2:0] cnt);
    ep_live = iface_ok({13'h0000, map[2:0]}, cnt) && (alt[map[2:0]] == map[`USRD_MAP_ALT]);
  endfunction

  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the setup word

  logic                  is_ep0;
  logic                  ep1_ok;
  logic                  ep2_ok;
  logic                  ep_ok;
  logic                  cfgd;
  logic                  ifx_ok;
  usrd_pkg::usrd_kind_t  kind_d;
  logic                  stall_d;
  logic                  data_d;
  logic [15:0]           len_d;
  logic [15:0]           reply_d;
  logic [1:0]            sel_d;

  always_comb
  begin
    // Fields arrive already split; value, index, length are low byte first
    is_ep0 = (i_setup.index == `USRD_EP0_OUT_IDX) || (i_setup.index == `USRD_EP0_IN_IDX);
    ep1_ok = (i_setup.index == `USRD_EP1_IDX) && ep_live(ep1_map_q, alt_cur_q, if_count_q);
    ep2_ok = (i_setup.index == `USRD_EP2_IDX) && ep_live(ep2_map_q, alt_cur_q, if_count_q);
    cfgd   = (state_q == usrd_pkg::USRD_CONFIGURED);
    ep_ok  = is_ep0 || (cfgd && (ep1_ok || ep2_ok));
    ifx_ok = iface_ok(i_setup.index, if_count_q);
    kind_d  = usrd_pkg::USRD_K_NONE;
    stall_d = 1'b0;
    data_d  = 1'b0;
    len_d   = `USRD_RST_WORD;
    reply_d = `USRD_RST_WORD;
    sel_d   = 2'b00;
    case (i_setup.code)
      `USRD_RQ_GET_STATUS:
        if (i_setup.rtype == `USRD_RT_STD_DEV_IN || i_setup.rtype == `USRD_RT_STD_EP_IN)
        begin
          kind_d  = usrd_pkg::USRD_K_GET_STATUS;
          stall_d = (i_setup.value != `USRD_RST_WORD) || (i_setup.length != `USRD_LEN_TWO)
                    || ((i_setup.rtype == `USRD_RT_STD_DEV_IN) ? (i_setup.index != `USRD_RST_WORD)
                                                               : !ep_ok);
          len_d   = `USRD_LEN_TWO;
          if (i_setup.rtype == `USRD_RT_STD_DEV_IN)
            reply_d = {15'h0000, device_status_low_q};
          else if (is_ep0)
            reply_d = {15'h0000, endpoint_halt_flag_q[0]};
          else
            reply_d = {15'h0000, ep1_ok ? endpoint_halt_flag_q[1] : endpoint_halt_flag_q[2]};
        end
      `USRD_RQ_CLR_FEATURE, `USRD_RQ_SET_FEATURE:
        if (i_setup.rtype == `USRD_RT_STD_DEV_OUT || i_setup.rtype == `USRD_RT_STD_EP_OUT)
        begin
          kind_d  = (i_setup.code == `USRD_RQ_CLR_FEATURE) ? usrd_pkg::USRD_K_CLR_FEATURE
                                                           : usrd_pkg::USRD_K_SET_FEATURE;
          stall_d = (i_setup.length != `USRD_RST_WORD)
                    || ((i_setup.rtype == `USRD_RT_STD_DEV_OUT)
                        ? (i_setup.value != `USRD_FEAT_WAKEUP || i_setup.index != `USRD_RST_WORD)
                        : (i_setup.value != `USRD_FEAT_EP_HALT || !ep_ok));
        end
      `USRD_RQ_SET_ADDRESS:
        if (i_setup.rtype == `USRD_RT_STD_DEV_OUT)
        begin
          kind_d  = usrd_pkg::USRD_K_SET_ADDRESS;
          stall_d = (i_setup.index != `USRD_RST_WORD) || (i_setup.length != `USRD_RST_WORD)
                    || (i_setup.value[15:`USRD_ADDR_TOP] != 9'h000);
        end
      `USRD_RQ_GET_DESC:
        if (i_setup.rtype == `USRD_RT_STD_DEV_IN && i_setup.index == `USRD_RST_WORD
            && (i_setup.value == `USRD_DESC_DEVICE || i_setup.value == `USRD_DESC_CONFIG))
        begin
          kind_d = usrd_pkg::USRD_K_GET_DESC;
          sel_d  = (i_setup.value == `USRD_DESC_DEVICE) ? 2'b01 : 2'b10;
          len_d  = min16(i_setup.length, (i_setup.value == `USRD_DESC_DEVICE)
                                         ? `USRD_DEV_DESC_LEN : cfg_len_q);
        end
      `USRD_RQ_GET_CONFIG:
        if (i_setup.rtype == `USRD_RT_STD_DEV_IN)
        begin
          kind_d  = usrd_pkg::USRD_K_GET_CONFIG;
          stall_d = (i_setup.value != `USRD_RST_WORD) || (i_setup.index != `USRD_RST_WORD)
                    || (i_setup.length != `USRD_LEN_ONE);
          len_d   = `USRD_LEN_ONE;
          reply_d = {15'h0000, conf_q};
        end
      `USRD_RQ_SET_CONFIG:
        if (i_setup.rtype == `USRD_RT_STD_DEV_OUT)
        begin
          kind_d  = usrd_pkg::USRD_K_SET_CONFIG;
          stall_d = (i_setup.value > `USRD_CFG_ONE) || (i_setup.index != `USRD_RST_WORD)
                    || (i_setup.length != `USRD_RST_WORD);
        end
      `USRD_RQ_GET_IFACE:
        if (i_setup.rtype == `USRD_RT_STD_IF_IN)
        begin
          kind_d  = usrd_pkg::USRD_K_GET_IFACE;
          stall_d = !cfgd || !ifx_ok || (i_setup.value != `USRD_RST_WORD)
                    || (i_setup.length != `USRD_LEN_ONE);
          len_d   = `USRD_LEN_ONE;
          reply_d = {15'h0000, alt_cur_q[i_setup.index[2:0]]};
        end
      `USRD_RQ_SET_IFACE:
        if (i_setup.rtype == `USRD_RT_STD_IF_OUT)
        begin
          kind_d  = usrd_pkg::USRD_K_SET_IFACE;
          stall_d = !cfgd || !ifx_ok || (i_setup.length != `USRD_RST_WORD)
                    || (i_setup.value > {15'h0000, alt_max_q[i_setup.index[2:0]]});
        end
      default:
        kind_d = usrd_pkg::USRD_K_NONE;
    endcase
    // Get-type requests carry a data stage, the rest go straight to status
    data_d = (kind_d == usrd_pkg::USRD_K_GET_STATUS) || (kind_d == usrd_pkg::USRD_K_GET_DESC)
             || (kind_d == usrd_pkg::USRD_K_GET_CONFIG)
             || (kind_d == usrd_pkg::USRD_K_GET_IFACE);
    // Halted ep0 stalls every standard request but ep0 get status, set feature and clear feature
    if (endpoint_halt_flag_q[0] && kind_d != usrd_pkg::USRD_K_NONE
        && !((kind_d == usrd_pkg::USRD_K_GET_STATUS || kind_d == usrd_pkg::USRD_K_SET_FEATURE)
             && i_setup.rtype[1] && is_ep0)
        && !(kind_d == usrd_pkg::USRD_K_CLR_FEATURE && i_setup.rtype[1] && is_ep0))
      stall_d = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer to the serial engine

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_resp       <= '0;
      kind_q       <= usrd_pkg::USRD_K_NONE;
      pkt_q        <= '0;
      pend_stall_q <= 1'b0;
    end
    else if (i_ce)
    begin
      o_resp.valid <= i_setup_stb;
      if (i_setup_stb)
      begin
        // Each new setup replaces the previous stall, so a stall never outlives it
        kind_q           <= kind_d;
        pkt_q            <= i_setup;
        pend_stall_q     <= stall_d;
        o_resp.stall     <= stall_d;
        o_resp.has_data  <= data_d;
        o_resp.fw_decode <= (kind_d == usrd_pkg::USRD_K_NONE);
        o_resp.zlp       <= (kind_d == usrd_pkg::USRD_K_NONE) && i_setup.rtype[`USRD_DIR_BIT]
                            && (i_setup.length == `USRD_RST_WORD);
        o_resp.xfer_len  <= len_d;
        o_resp.reply     <= reply_d;
        o_resp.desc_sel  <= sel_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device state, address and feature bits, applied on the status-stage ACK

  logic apply;
  assign apply = i_status_ack && !pend_stall_q && !o_resp.has_data && !o_resp.fw_decode;

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q              <= usrd_pkg::USRD_DEFAULT;
      addr_q               <= 7'h00;
      conf_q               <= 1'b0;
      device_status_low_q  <= 1'b0;
      endpoint_halt_flag_q <= 3'b000;
      alt_cur_q            <= '0;
      o_toggle_reset       <= 3'b000;
      o_clear_irq          <= 1'b0;
      o_config_irq         <= 1'b0;
      o_fw_irq             <= 1'b0;
    end
    else if (i_ce)
    begin
      o_toggle_reset <= 3'b000;
      o_clear_irq    <= 1'b0;
      o_config_irq   <= 1'b0;
      o_fw_irq       <= i_setup_stb && (kind_d == usrd_pkg::USRD_K_NONE);
      if (apply)
      begin
        case (kind_q)
          usrd_pkg::USRD_K_CLR_FEATURE:
          begin
            o_clear_irq <= 1'b1;
            if (!pkt_q.rtype[1])
              device_status_low_q <= 1'b0;
            else if (pkt_q.index == `USRD_EP1_IDX)
            begin
              endpoint_halt_flag_q[1] <= 1'b0;
              o_toggle_reset[1]       <= 1'b1;
            end
            else if (pkt_q.index == `USRD_EP2_IDX)
            begin
              endpoint_halt_flag_q[2] <= 1'b0;
              o_toggle_reset[2]       <= 1'b1;
            end
            else
            begin
              endpoint_halt_flag_q[0] <= 1'b0;
              o_toggle_reset[0]       <= 1'b1;
            end
          end
          usrd_pkg::USRD_K_SET_FEATURE:
            if (!pkt_q.rtype[1])
              device_status_low_q <= 1'b1;
            else if (pkt_q.index == `USRD_EP1_IDX)
              endpoint_halt_flag_q[1] <= 1'b1;
            else if (pkt_q.index == `USRD_EP2_IDX)
              endpoint_halt_flag_q[2] <= 1'b1;
            else
              endpoint_halt_flag_q[0] <= 1'b1;
          usrd_pkg::USRD_K_SET_ADDRESS:
          begin
            addr_q <= pkt_q.value[6:0];
            if (state_q != usrd_pkg::USRD_CONFIGURED)
              state_q <= (pkt_q.value[6:0] == 7'h00) ? usrd_pkg::USRD_DEFAULT
                                                     : usrd_pkg::USRD_ADDRESSED;
          end
          usrd_pkg::USRD_K_SET_CONFIG:
          begin
            conf_q               <= pkt_q.value[0];
            endpoint_halt_flag_q <= 3'b000;
            alt_cur_q            <= '0;
            o_toggle_reset       <= 3'b111;
            o_config_irq         <= 1'b1;
            if (pkt_q.value[0])
              state_q <= usrd_pkg::USRD_CONFIGURED;
            else if (state_q == usrd_pkg::USRD_CONFIGURED)
              state_q <= usrd_pkg::USRD_ADDRESSED;
          end
          usrd_pkg::USRD_K_SET_IFACE:
            alt_cur_q[pkt_q.index[2:0]] <= pkt_q.value[0];
          default:
            conf_q <= conf_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  logic clr_evt;
  assign clr_evt = apply && (kind_q == usrd_pkg::USRD_K_CLR_FEATURE);

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      if_count_q            <= 3'h0;
      alt_max_q             <= '0;
      ep1_map_q             <= 4'h0;
      ep2_map_q             <= 4'h0;
      cfg_len_q             <= `USRD_RST_WORD;
      ctrl_go_q             <= 1'b0;
      clear_request_flags_q <= 4'h0;
    end
    else if (i_ce)
    begin
      if (i_reg_wr)
      begin
        case (i_reg_addr)
          `USRD_REG_CTRL:      ctrl_go_q  <= i_reg_wdata[0];
          `USRD_REG_IFCOUNT:   if_count_q <= i_reg_wdata[2:0];
          `USRD_REG_ALTMAX:    alt_max_q  <= i_reg_wdata[NIF-1:0];
          `USRD_REG_EP1MAP:    ep1_map_q  <= i_reg_wdata[3:0];
          `USRD_REG_EP2MAP:    ep2_map_q  <= i_reg_wdata[3:0];
          `USRD_REG_CFGLEN_LO: cfg_len_q[7:0]  <= i_reg_wdata;
          `USRD_REG_CFGLEN_HI: cfg_len_q[15:8] <= i_reg_wdata;
          default:             ctrl_go_q  <= ctrl_go_q;
        endcase
      end
      // Write one to clear; a new clear request in the same cycle wins
      clear_request_flags_q <= (clear_request_flags_q
                               & ~((i_reg_wr && i_reg_addr == `USRD_REG_CLRFLAGS)
                                   ? i_reg_wdata[3:0] : 4'h0))
                               | (clr_evt ? { pkt_q.index == `USRD_EP2_IDX,
                                              pkt_q.index == `USRD_EP1_IDX,
                                              pkt_q.rtype[1] && !pkt_q.index[0]
                                                && !pkt_q.index[1],
                                              !pkt_q.rtype[1] } : 4'h0);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_reg_rdata <= `USRD_RST_BYTE;
      o_usb_addr  <= 7'h00;
      o_dev_state <= 2'b00;
    end
    else if (i_ce)
    begin
      o_usb_addr  <= addr_q;
      o_dev_state <= state_q;
      o_reg_rdata <= `USRD_RST_BYTE;
      if (i_reg_rd)
      begin
        case (i_reg_addr)
          `USRD_REG_CTRL:      o_reg_rdata <= {7'h00, ctrl_go_q};
          `USRD_REG_IFCOUNT:   o_reg_rdata <= {5'h00, if_count_q};
          `USRD_REG_ALTMAX:    o_reg_rdata <= 8'(alt_max_q);
          `USRD_REG_EP1MAP:    o_reg_rdata <= {4'h0, ep1_map_q};
          `USRD_REG_EP2MAP:    o_reg_rdata <= {4'h0, ep2_map_q};
          `USRD_REG_CFGLEN_LO: o_reg_rdata <= cfg_len_q[7:0];
          `USRD_REG_CFGLEN_HI: o_reg_rdata <= cfg_len_q[15:8];
          `USRD_REG_CLRFLAGS:  o_reg_rdata <= {4'h0, clear_request_flags_q};
          `USRD_REG_STATUS:    o_reg_rdata <= {1'b0, state_q, conf_q,
                                               endpoint_halt_flag_q, device_status_low_q};
          `USRD_REG_ADDR:      o_reg_rdata <= {1'b0, addr_q};
          `USRD_REG_ALTCUR:    o_reg_rdata <= 8'(alt_cur_q);
          default:             o_reg_rdata <= `USRD_RST_BYTE;
        endcase
      end
    end
  end

endmodule

/* bench/usrd_host.sv */
/* Host model: sends setup packets and status stage ACKs.
   Assumes it shares the decoder clock and is driven by the bench. */
`timescale 1ns/100ps
module usrd_host
(
  input  wire logic             i_sys_clk,
  output usrd_pkg::usrd_setup_t o_setup,
  output logic                  o_stb,
  output logic                  o_ack
);
  initial
  begin
    o_setup = '0;
    o_stb = 1'b0;
    o_ack = 1'b0;
  end
  // Always a whole eight-byte setup before any stage
  task automatic send(input usrd_pkg::usrd_setup_t s);
    @(posedge i_sys_clk);
    o_setup <= s;
    o_stb <= 1'b1;
    @(posedge i_sys_clk);
    o_stb <= 1'b0;
    // Stale bytes are inverted so nothing can lean on them
    o_setup <= ~s;
    #1;
  endtask
  task automatic status_ack();
    @(posedge i_sys_clk);
    o_ack <= 1'b1;
    @(posedge i_sys_clk);
    o_ack <= 1'b0;
    #1;
  endtask
endmodule

/* bench/usrd_checker.sv */
/* Port assertions of the request decoder.
   Assumes one clock domain and a bind from the bench. */
`timescale 1ns/100ps
module usrd_checker
(
  input wire logic                  i_sys_clk,
  input wire logic                  i_rst_n,
  input wire logic                  i_ce,
  input wire usrd_pkg::usrd_setup_t i_setup,
  input wire logic                  i_setup_stb,
  input wire logic                  i_status_ack,
  input wire usrd_pkg::usrd_resp_t  o_resp,
  input wire logic [1:0]            o_dev_state,
  input wire logic [2:0]            o_toggle_reset,
  input wire logic                  o_clear_irq,
  input wire logic                  o_fw_irq
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic stb;
  assign stb = i_setup_stb & i_ce;
  ////////////////////////////////////////
  property p_answer;
    stb |=> o_resp.valid && (o_fw_irq == o_resp.fw_decode);
  endproperty
  a_answer: assert property (p_answer) else $error("setup not answered");
  property p_cause;
    o_resp.valid |-> $past(stb);
  endproperty
  a_cause: assert property (p_cause) else $error("answer without setup");
  property p_nodata;
    stb && !i_setup.rtype[7] && i_setup.code inside {8'h01, 8'h03, 8'h05, 8'h09, 8'h0b}
      |=> !o_resp.has_data;
  endproperty
  a_nodata: assert property (p_nodata) else $error("data stage on set request");
  property p_iface;
    stb && i_setup.rtype == 8'h81 && i_setup.code == 8'h0a && o_dev_state != 2'b11
      |=> o_resp.stall;
  endproperty
  a_iface: assert property (p_iface) else $error("interface request not stalled");
  property p_desc;
    stb && i_setup.rtype == 8'h80 && i_setup.code == 8'h06 && i_setup.value == 16'h0100
      && i_setup.index == 16'h0000
      |=> o_resp.stall || o_resp.xfer_len == ($past(i_setup.length) < 16'h0012 ?
      $past(i_setup.length) : 16'h0012);
  endproperty
  a_desc: assert property (p_desc) else $error("descriptor length wrong");
  property p_cfg;
    stb && i_setup.code == 8'h09 && i_setup.rtype == 8'h00 && i_setup.value > 16'h0001
      |=> o_resp.stall;
  endproperty
  a_cfg: assert property (p_cfg) else $error("bad configuration accepted");
  property p_fw;
    o_resp.valid && o_resp.fw_decode |-> !o_resp.stall;
  endproperty
  a_fw: assert property (p_fw) else $error("firmware request stalled");
  property p_zlp;
    stb && i_setup.rtype[7] && i_setup.length == 16'h0000 && !(i_setup.code inside
      {8'h00, 8'h01, 8'h03, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b}) |=> o_resp.zlp;
  endproperty
  a_zlp: assert property (p_zlp) else $error("no zero length packet");
  property p_clr;
    o_clear_irq |-> $past(i_status_ack);
  endproperty
  a_clr: assert property (p_clr) else $error("clear before status ack");
  property p_tog;
    o_toggle_reset != 3'h0 |-> $past(i_status_ack);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle reset without ack");
  property p_state;
    $changed(o_dev_state) |-> o_dev_state != 2'b10 && ($past(i_status_ack) ||
      $past(i_status_ack, 2));
  endproperty
  a_state: assert property (p_state) else $error("state moved without ack");
endmodule

/* bench/usrd_decoder_tb.sv */
/* Self-checking bench of the request decoder.
   Assumes the package, decoder, host model and checker are compiled first. */
`timescale 1ns/100ps
module usrd_decoder_tb;
  logic                  i_sys_clk = 1'b0;
  logic                  i_rst_n = 1'b0;
  logic [3:0]            addr = 4'h0;
  logic [7:0]            wdata = 8'h00;
  logic                  wr = 1'b0;
  logic                  rd = 1'b0;
  logic [7:0]            rdata;
  usrd_pkg::usrd_setup_t setup;
  logic                  stb;
  logic                  ack;
  usrd_pkg::usrd_resp_t  resp;
  logic [1:0]            st;
  logic [2:0]            tog;
  logic                  clr_irq;
  logic                  fw_irq;
  logic [6:0]            usb_addr;
  logic                  cfg_irq;
  int                    err_count = 0;
  int                    total_checks = 0;
  always #4 i_sys_clk = ~i_sys_clk;
  usrd_host u_host (.i_sys_clk(i_sys_clk), .o_setup(setup), .o_stb(stb), .o_ack(ack));
  usrd_decoder u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_setup(setup),
    .i_setup_stb(stb), .i_status_ack(ack), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_resp(resp), .o_usb_addr(usb_addr),
    .o_dev_state(st), .o_toggle_reset(tog), .o_clear_irq(clr_irq), .o_config_irq(cfg_irq),
    .o_fw_irq(fw_irq));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_sys_clk);
    rd <= 1'b0;
    #1 check("reg", rdata, exp);
  endtask
  task automatic rq(input logic [7:0] rt, cd, input logic [15:0] v, ix, ln, input logic s);
    u_host.send({ln, ix, v, cd, rt});
    check("stall", resp.stall, s);
  endtask
  // Whole run is about 60 cycles; the limit at 2500 cycles leaves wide margin
  initial
  begin
    #20000 err_count++;
    close_out();
  end
  initial
  begin
    repeat (12) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd_chk(4'h8, 8'h00);
    rd_chk(4'hf, 8'h00);
    wr_reg(4'h1, 8'h02);
    rd_chk(4'h1, 8'h02);
    rq(8'h80, 8'h06, 16'h0100, 16'h0000, 16'h0040, 1'b0);
    check("len", resp.xfer_len, 16'h0012);
    check("data", resp.has_data, 1'b1);
    rq(8'h81, 8'h0a, 16'h0000, 16'h0000, 16'h0001, 1'b1);
    rq(8'h02, 8'h03, 16'h0000, 16'h0000, 16'h0000, 1'b0);
    check("data", resp.has_data, 1'b0);
    u_host.status_ack();
    rd_chk(4'h8, 8'h02);
    rq(8'h80, 8'h06, 16'h0100, 16'h0000, 16'h0040, 1'b1);
    rq(8'h82, 8'h00, 16'h0000, 16'h0080, 16'h0002, 1'b0);
    check("reply", resp.reply, 16'h0001);
    rq(8'h02, 8'h01, 16'h0000, 16'h0000, 16'h0000, 1'b0);
    u_host.status_ack();
    check("irq", clr_irq, 1'b1);
    check("toggle", tog, 3'h1);
    rd_chk(4'h8, 8'h00);
    rd_chk(4'h7, 8'h02);
    rq(8'h00, 8'h09, 16'h0002, 16'h0000, 16'h0000, 1'b1);
    rq(8'h80, 8'h06, 16'h0100, 16'h0000, 16'h0005, 1'b0);
    check("len", resp.xfer_len, 16'h0005);
    rq(8'h80, 8'h0c, 16'h0000, 16'h0000, 16'h0000, 1'b0);
    check("fw", {resp.fw_decode, fw_irq}, 2'b11);
    check("zlp", resp.zlp, 1'b1);
    rq(8'h00, 8'h05, 16'h0005, 16'h0000, 16'h0000, 1'b0);
    u_host.status_ack();
    rq(8'h00, 8'h09, 16'h0001, 16'h0000, 16'h0000, 1'b0);
    u_host.status_ack();
    check("cfg irq", cfg_irq, 1'b1);
    rd_chk(4'h8, 8'h70);
    check("state", st, 2'b11);
    check("addr", usb_addr, 7'h05);
    rq(8'h81, 8'h0a, 16'h0000, 16'h0000, 16'h0001, 1'b0);
    close_out();
  end
endmodule
bind usrd_decoder usrd_checker u_chk (.*);
